//--- core/pgs_pkg.sv
/*
 * Constants, register map and enumerations for the panel gain stage
 * selector. Assumes a 100 MHz system clock and an APB register bus.
 */
package pgs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int HOLD_MS       = 2000;
    localparam int HOLD_CYCLES   = HOLD_MS * (CLK_HZ / 1000);
    localparam int FLASH_MS      = 250;
    localparam int FLASH_CYCLES  = FLASH_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_US   = 5000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W         = 28;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR    = 8'h00;
    localparam logic [7:0] PLUGIN_ADDR  = 8'h04;
    localparam logic [7:0] STATUS_ADDR  = 8'h08;
    localparam logic [7:0] EVENT_ADDR   = 8'h0c;

    // CTRL fields
    localparam int CTRL_LINK_BIT     = 0;
    // PLUGIN fields: per channel present, enabled, three-stage
    localparam int PLG_PRES0_BIT     = 0;
    localparam int PLG_EN0_BIT       = 1;
    localparam int PLG_THREE0_BIT    = 2;
    localparam int PLG_PRES1_BIT     = 4;
    localparam int PLG_EN1_BIT       = 5;
    localparam int PLG_THREE1_BIT    = 6;
    // Host stage write: bit 8 strobe-on-write, bits 10:9 stage
    localparam int PLG_STG_WR_BIT    = 8;
    localparam int PLG_STG_LSB       = 9;

    // Reset values
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] PLUGIN_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] STAGE_ONE   = 2'h0;
    localparam logic [1:0] STAGE_TWO   = 2'h1;
    localparam logic [1:0] STAGE_THREE = 2'h2;

    localparam logic [1:0] RING_GREEN  = 2'h0;
    localparam logic [1:0] RING_ORANGE = 2'h1;
    localparam logic [1:0] RING_AMBER  = 2'h2;

    typedef enum logic [1:0] {
        PGS_PANEL_IDLE,
        PGS_PANEL_INPUT,
        PGS_PANEL_STAGE
    } pgs_panel_t;

endpackage

//--- core/pgs_debounce.sv
/*
 * Synchroniser and debouncer for one front-panel push switch.
 * Assumes a raw, bouncing, active-high switch level from a pin.
 */
`timescale 1ns/10ps
module pgs_debounce
    import pgs_pkg::*;
#(
    parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Switch
    input  wire logic raw,
    output logic      level
);

    logic             sync_a;
    logic             sync_b;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_level;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    always_comb begin
        next_cnt   = '0;
        next_level = level;
        if (sync_b != level) begin
            if (cnt == CNT_W'(DEBOUNCE_COUNT - 1)) begin
                next_level = sync_b;
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            cnt    <= '0;
            level  <= 1'b0;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
            cnt    <= next_cnt;
            level  <= next_level;
        end
    end

endmodule

//--- core/pgs_panel.sv
/*
 * Front-panel gain stage selector: channel select, stage cycle mode,
 * channel indicators and ring colour, with an APB register slave.
 * Assumes raw switch pins and host software writing plug-in state.
 */
// Implementation choices: the register offsets and the APB slave port.
// Behaviour
// - Ring is orange when the selected channel holds an emulation plug-in in input mode.
// - Emulation ring colour shows only in input mode on the plug-in's channel.
// - A disabled plug-in returns the ring to green.
// - In input mode each input-mode button press alternates the channel.
// - In input mode a short knob press also alternates the channel.
// - The selected channel's indicator is lit, both when stereo-linked.
// - In input mode a two-second knob hold with an enabled plug-in present enters stage cycle mode.
// - Stage cycle mode is active on at most one channel.
// - The selected channel's indicator flashes in stage cycle mode.
// - Before stage cycle mode the knob controls only stage one.
// - Each short press in stage cycle mode advances the stage over two or three.
// - Ring is orange, amber, green for stages one, two, three.
// - Hold, plug-in loss or a button channel change leaves stage cycle mode.
// - Leaving stage cycle mode restores toggling, steady LED and stage one.
// - Knob stage and plug-in stage stay mirrored both ways.
`timescale 1ns/10ps
module pgs_panel
    import pgs_pkg::*;
#(
    parameter int HOLD_COUNT     = HOLD_CYCLES,
    parameter int FLASH_COUNT    = FLASH_CYCLES,
    parameter int DEBOUNCE_COUNT = DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Panel pins
    input  wire logic        knob_switch,
    input  wire logic        input_mode_switch,
    output logic             first_channel_indicator,
    output logic             second_channel_indicator,
    output logic [1:0]       ring_colour,
    // Controlled stage for the host mirror
    output logic [1:0]       knob_stage,
    output logic             stage_mode
);

    logic             knob_lvl;
    logic             btn_lvl;
    logic             knob_d;
    logic             btn_d;
    logic             next_knob_d;
    logic             next_btn_d;
    logic [31:0]      ctrl;
    logic [31:0]      plugin;
    logic [31:0]      next_ctrl;
    logic [31:0]      next_plugin;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    pgs_panel_t       state;
    pgs_panel_t       next_state;
    logic             sel;
    logic             next_sel;
    logic             stg_ch;
    logic             next_stg_ch;
    logic [1:0]       stage;
    logic [1:0]       next_stage;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] next_hold_cnt;
    logic             held;
    logic             next_held;
    logic [CNT_W-1:0] flash_cnt;
    logic [CNT_W-1:0] next_flash_cnt;
    logic             blink;
    logic             next_blink;
    logic             next_ind1;
    logic             next_ind2;
    logic [1:0]       next_ring;
    logic             pres_sel;
    logic             en_sel;
    logic             three_sel;
    logic             stg_ok;
    logic             knob_rel;
    logic             btn_press;
    logic             hold_hit;
    logic             host_wr;
    logic             access;
    logic             commit;

    // ------------------------------------------------------------
    // Switch inputs
    // ------------------------------------------------------------
    pgs_debounce #(.DEBOUNCE_COUNT(DEBOUNCE_COUNT)) u_knob (
        .clk    (clk),
        .resetn (resetn),
        .raw    (knob_switch),
        .level  (knob_lvl)
    );

    pgs_debounce #(.DEBOUNCE_COUNT(DEBOUNCE_COUNT)) u_btn (
        .clk    (clk),
        .resetn (resetn),
        .raw    (input_mode_switch),
        .level  (btn_lvl)
    );

    // ------------------------------------------------------------
    // Plug-in state of the selected and stage channels
    // ------------------------------------------------------------
    always_comb begin
        pres_sel  = sel ? plugin[PLG_PRES1_BIT]  : plugin[PLG_PRES0_BIT];
        en_sel    = sel ? plugin[PLG_EN1_BIT]    : plugin[PLG_EN0_BIT];
        three_sel = stg_ch ? plugin[PLG_THREE1_BIT]
                           : plugin[PLG_THREE0_BIT];
        stg_ok    = stg_ch ? (plugin[PLG_PRES1_BIT] & plugin[PLG_EN1_BIT])
                           : (plugin[PLG_PRES0_BIT] & plugin[PLG_EN0_BIT]);
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_comb begin
        access       = psel & penable & ~pready;
        commit       = psel & penable & pready & pwrite;
        next_pready  = access;
        next_pslverr = 1'b0;
        next_prdata  = '0;
        next_ctrl    = ctrl;
        next_plugin  = plugin;
        host_wr      = 1'b0;
        if (access) begin
            unique case (paddr)
                CTRL_ADDR:   next_prdata = ctrl;
                PLUGIN_ADDR: next_prdata = plugin;
                STATUS_ADDR: begin
                    next_prdata = {26'h0, state == PGS_PANEL_STAGE,
                                   stg_ch, stage, sel,
                                   state != PGS_PANEL_IDLE};
                end
                EVENT_ADDR: begin
                    next_prdata = {30'h0, btn_lvl, knob_lvl};
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        // Writes land on the completing edge
        if (commit && paddr == CTRL_ADDR) begin
            next_ctrl = pwdata;
        end
        if (commit && paddr == PLUGIN_ADDR) begin
            next_plugin = pwdata;
            host_wr     = pwdata[PLG_STG_WR_BIT];
        end
        next_plugin[PLG_STG_WR_BIT] = 1'b0;
    end

    // ------------------------------------------------------------
    // Press, release and hold detection
    // ------------------------------------------------------------
    always_comb begin
        next_knob_d   = knob_lvl;
        next_btn_d    = btn_lvl;
        btn_press     = btn_lvl & ~btn_d;
        hold_hit      = knob_lvl & ~held
                        & (hold_cnt == CNT_W'(HOLD_COUNT - 1));
        knob_rel      = ~knob_lvl & knob_d & ~held;
        next_hold_cnt = '0;
        next_held     = 1'b0;
        if (knob_lvl) begin
            next_held     = held | hold_hit;
            next_hold_cnt = hold_hit || held ? hold_cnt
                                             : hold_cnt + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Panel mode, channel and stage
    // ------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_sel    = sel;
        next_stg_ch = stg_ch;
        next_stage  = stage;
        unique case (state)
            PGS_PANEL_IDLE: begin
                if (btn_press) next_state = PGS_PANEL_INPUT;
            end
            PGS_PANEL_INPUT: begin
                next_stage = STAGE_ONE;
                if (btn_press || knob_rel) begin
                    next_sel = ~sel;
                end else if (hold_hit && pres_sel && en_sel) begin
                    next_state  = PGS_PANEL_STAGE;
                    next_stg_ch = sel;
                end
            end
            PGS_PANEL_STAGE: begin
                if (btn_press || hold_hit || !stg_ok) begin
                    next_state = PGS_PANEL_INPUT;
                    next_stage = STAGE_ONE;
                    if (btn_press) next_sel = ~sel;
                end else if (host_wr && pwdata[PLG_STG_LSB +: 2]
                             <= (three_sel ? STAGE_THREE : STAGE_TWO)) begin
                    next_stage = pwdata[PLG_STG_LSB +: 2];
                end else if (knob_rel) begin
                    if (stage == STAGE_ONE) begin
                        next_stage = STAGE_TWO;
                    end else if (stage == STAGE_TWO && three_sel) begin
                        next_stage = STAGE_THREE;
                    end else begin
                        next_stage = STAGE_ONE;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Indicators and ring
    // ------------------------------------------------------------
    always_comb begin
        next_flash_cnt = flash_cnt + CNT_W'(1);
        next_blink     = blink;
        if (flash_cnt == CNT_W'(FLASH_COUNT - 1)) begin
            next_flash_cnt = '0;
            next_blink     = ~blink;
        end
        next_ind1 = ~sel | ctrl[CTRL_LINK_BIT];
        next_ind2 = sel | ctrl[CTRL_LINK_BIT];
        if (next_state == PGS_PANEL_STAGE) begin
            if (next_sel) next_ind2 = blink;
            else          next_ind1 = blink;
        end
        next_ring = RING_GREEN;
        if (next_state == PGS_PANEL_STAGE) begin
            unique case (next_stage)
                STAGE_TWO:   next_ring = RING_AMBER;
                STAGE_THREE: next_ring = RING_GREEN;
                default:     next_ring = RING_ORANGE;
            endcase
        end else if (next_state == PGS_PANEL_INPUT
                     && pres_sel && en_sel && next_sel == sel) begin
            next_ring = RING_ORANGE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata    <= '0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            ctrl      <= CTRL_RESET;
            plugin    <= PLUGIN_RESET;
            knob_d    <= 1'b0;
            btn_d     <= 1'b0;
            hold_cnt  <= '0;
            held      <= 1'b0;
            state     <= PGS_PANEL_IDLE;
            sel       <= 1'b0;
            stg_ch    <= 1'b0;
            stage     <= STAGE_ONE;
            flash_cnt <= '0;
            blink     <= 1'b0;
            first_channel_indicator  <= 1'b0;
            second_channel_indicator <= 1'b0;
            ring_colour <= RING_GREEN;
            knob_stage  <= STAGE_ONE;
            stage_mode  <= 1'b0;
        end else begin
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            ctrl      <= next_ctrl;
            plugin    <= next_plugin;
            knob_d    <= next_knob_d;
            btn_d     <= next_btn_d;
            hold_cnt  <= next_hold_cnt;
            held      <= next_held;
            state     <= next_state;
            sel       <= next_sel;
            stg_ch    <= next_stg_ch;
            stage     <= next_stage;
            flash_cnt <= next_flash_cnt;
            blink     <= next_blink;
            first_channel_indicator  <= next_ind1;
            second_channel_indicator <= next_ind2;
            ring_colour <= next_ring;
            knob_stage  <= next_stage;
            stage_mode  <= next_state == PGS_PANEL_STAGE;
        end
    end

endmodule

//--- verif/pgs_panel_props.sv
/*
 * Port assertions for the panel gain stage selector.
 * Assumes a bind onto pgs_panel with its parameters handed on.
 */
`timescale 1ns/10ps
module pgs_panel_props
    import pgs_pkg::*;
#(
    parameter int HOLD_COUNT  = HOLD_CYCLES,
    parameter int FLASH_COUNT = FLASH_CYCLES
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // APB
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Panel
    input wire logic       first_channel_indicator,
    input wire logic       second_channel_indicator,
    input wire logic [1:0] ring_colour,
    input wire logic [1:0] knob_stage,
    input wire logic       stage_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic [1:0] ind;
    logic [1:0] prev_ind;
    logic       mapped;
    int         still;

    assign ind    = {first_channel_indicator, second_channel_indicator};
    assign mapped = paddr inside {CTRL_ADDR, PLUGIN_ADDR, STATUS_ADDR,
                                  EVENT_ADDR};

    // ------------------------------------------------------------
    // Cycles without an indicator change in stage mode
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_ind <= 2'h0;
            still    <= 0;
        end else begin
            prev_ind <= ind;
            still    <= (!stage_mode || prev_ind != ind) ? 0 : still + 1;
        end
    end

    sequence s_access;
        psel && penable && !pready;
    endsequence

    sequence s_steady;
        $stable(ind) [*4];
    endsequence

    a_ready_answer: assert property (s_access |=> pready)
        else $error("no answer after access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not follow address map");
    a_stage_colour: assert property (
        stage_mode |-> ring_colour == (knob_stage == STAGE_ONE ? RING_ORANGE
            : knob_stage == STAGE_TWO ? RING_AMBER : RING_GREEN))
        else $error("ring colour does not match stage");
    a_stage_one_idle: assert property (
        !stage_mode |-> knob_stage == STAGE_ONE)
        else $error("stage not one outside stage mode");
    a_amber_stage: assert property (
        ring_colour == RING_AMBER |-> stage_mode)
        else $error("amber ring outside stage mode");
    a_flash_period: assert property (still <= FLASH_COUNT + 2)
        else $error("indicator not flashing in stage mode");
    a_exit_steady: assert property (
        $fell(stage_mode) |-> ##2 s_steady)
        else $error("indicator flashing after stage mode exit");
    a_codes_legal: assert property (ring_colour != 2'h3 && knob_stage != 2'h3)
        else $error("illegal ring or stage code");
endmodule

//--- verif/pgs_host.sv
/*
 * Host application model: reports plug-in state over APB.
 * Assumes the bench calls its tasks; it answers no bus itself.
 */
`timescale 1ns/10ps
module pgs_host
    import pgs_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // One APB transfer, bounded wait for pready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] d,
                        output logic e, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        ok = (pready === 1'b1);
        d  = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~wd;
    endtask

    // Plug-in state, optionally with a stage picked in the plug-in
    task automatic report(input logic [31:0] v, input logic stg,
                          input logic [1:0] s, output logic ok);
        logic [31:0] d;
        logic        e;
        logic [31:0] w;
        w = v & ~32'h0000_0700;
        if (stg) begin
            w = w | 32'h0000_0100 | (32'(s) << PLG_STG_LSB);
        end
        xfer(1'b1, PLUGIN_ADDR, w, d, e, ok);
    endtask
endmodule

//--- verif/pgs_panel_tb.sv
/*
 * Self-checking bench for the panel gain stage selector.
 * Assumes pgs_panel, the host model and the port checker.
 */
`timescale 1ns/10ps
module pgs_panel_tb
    import pgs_pkg::*;
;
    localparam int HOLD  = 100;
    localparam int FLASH = 8;
    localparam int DEB   = 20;
    localparam int SHORT = DEB + 20;
    localparam int LONG  = HOLD + 50;

    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] d;
        logic        e;
    } pgs_row_t;

    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        knob_switch, input_mode_switch;
    logic        first_channel_indicator, second_channel_indicator;
    logic [1:0]  ring_colour, knob_stage;
    logic        stage_mode;
    int          fail_count, checks_done;
    pgs_row_t    rows [7];

    pgs_panel #(.HOLD_COUNT(HOLD), .FLASH_COUNT(FLASH),
                .DEBOUNCE_COUNT(DEB)) u_pgs_panel (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .knob_switch(knob_switch),
        .input_mode_switch(input_mode_switch),
        .first_channel_indicator(first_channel_indicator),
        .second_channel_indicator(second_channel_indicator),
        .ring_colour(ring_colour), .knob_stage(knob_stage),
        .stage_mode(stage_mode));

    pgs_host u_host (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic need(input logic ok);
        if (ok !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d,
                       output logic e);
        logic ok;
        u_host.xfer(w, a, wd, d, e, ok);
        need(ok);
    endtask

    task automatic host(input logic [31:0] v, input logic stg,
                        input logic [1:0] s);
        logic ok;
        u_host.report(v, stg, s, ok);
        need(ok);
    endtask

    task automatic press(input logic knob, input int hi);
        @(posedge clk);
        knob_switch       <= knob;
        input_mode_switch <= !knob;
        repeat (hi) @(posedge clk);
        knob_switch       <= 1'b0;
        input_mode_switch <= 1'b0;
        repeat (DEB + 10) @(posedge clk);
    endtask

    // Indicators, ring, mode, stage; indicators skipped while flashing
    task automatic look(input logic [6:0] x);
        logic [6:0] g;
        repeat (3) @(posedge clk);
        g = {first_channel_indicator, second_channel_indicator,
             ring_colour, stage_mode, knob_stage};
        if (x[2]) g[6:5] = x[6:5];
        chk("panel", 32'(x), 32'(g));
    endtask

    task automatic stat(input logic [31:0] m, input logic [31:0] x);
        logic [31:0] d;
        logic        e;
        bus(1'b0, STATUS_ADDR, 32'h0, d, e);
        chk("status", x, d & m);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        logic [31:0] d;
        logic        e;
        fail_count        = 0;
        checks_done       = 0;
        resetn            = 1'b0;
        knob_switch       = 1'b0;
        input_mode_switch = 1'b0;
        rows = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
                 '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
                 '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
                 '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
                 '{1'b1, 8'h08, 32'hffffffff, 32'h0, 1'b0},
                 '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
                 '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}};
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        look({2'b10, RING_GREEN, 1'b0, STAGE_ONE});
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].wd, d, e);
            if (!rows[i].w && !rows[i].e) chk("rdata", rows[i].d, d);
            chk("pslverr", 32'(rows[i].e), 32'(e));
        end
        press(1'b0, SHORT);
        look({2'b10, RING_GREEN, 1'b0, STAGE_ONE});
        host(32'h07, 1'b0, STAGE_ONE);
        look({2'b10, RING_ORANGE, 1'b0, STAGE_ONE});
        press(1'b0, SHORT);
        look({2'b01, RING_GREEN, 1'b0, STAGE_ONE});
        press(1'b1, SHORT);
        look({2'b10, RING_ORANGE, 1'b0, STAGE_ONE});
        press(1'b1, LONG);
        stat(32'h22, 32'h20);
        press(1'b1, SHORT);
        look({2'b00, RING_AMBER, 1'b1, STAGE_TWO});
        press(1'b1, SHORT);
        look({2'b00, RING_GREEN, 1'b1, STAGE_THREE});
        press(1'b1, SHORT);
        look({2'b00, RING_ORANGE, 1'b1, STAGE_ONE});
        host(32'h07, 1'b1, STAGE_TWO);
        look({2'b00, RING_AMBER, 1'b1, STAGE_TWO});
        host(32'h05, 1'b0, STAGE_ONE);
        look({2'b10, RING_GREEN, 1'b0, STAGE_ONE});
        host(32'h37, 1'b0, STAGE_ONE);
        press(1'b1, LONG);
        press(1'b1, SHORT);
        press(1'b0, SHORT);
        look({2'b01, RING_ORANGE, 1'b0, STAGE_ONE});
        press(1'b1, LONG);
        stat(32'h32, 32'h32);
        press(1'b1, SHORT);
        look({2'b00, RING_AMBER, 1'b1, STAGE_TWO});
        press(1'b1, SHORT);
        look({2'b00, RING_ORANGE, 1'b1, STAGE_ONE});
        press(1'b1, LONG);
        look({2'b01, RING_ORANGE, 1'b0, STAGE_ONE});
        bus(1'b1, CTRL_ADDR, 32'h1, d, e);
        look({2'b11, RING_ORANGE, 1'b0, STAGE_ONE});
        // Mid-run reset: outputs cleared, panel idle, link off
        resetn <= 1'b0;
        @(posedge clk);
        chk("reset", 32'h0, 32'({first_channel_indicator,
                                 second_channel_indicator, ring_colour,
                                 stage_mode, knob_stage, pready}));
        resetn <= 1'b1;
        look({2'b10, RING_GREEN, 1'b0, STAGE_ONE});
        stat(32'h3f, 32'h0);
        bus(1'b0, CTRL_ADDR, 32'h0, d, e);
        chk("ctrl", 32'h0, d);
        print_verdict();
    end
endmodule

bind pgs_panel pgs_panel_props #(
    .HOLD_COUNT (HOLD_COUNT),
    .FLASH_COUNT(FLASH_COUNT)
) u_props (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .first_channel_indicator(first_channel_indicator),
    .second_channel_indicator(second_channel_indicator),
    .ring_colour(ring_colour), .knob_stage(knob_stage),
    .stage_mode(stage_mode));
